// >>> rotd_consts.vh
// constants for the oscillator digital trim block
`ifndef ROTD_CONSTS_VH
`define ROTD_CONSTS_VH
`define ROTD_TRIM_ADDR 8'h08
`define ROTD_TRIM_RESET 8'h00
`define ROTD_DIR_BIT 7
`define ROTD_MAG_MSB 6
`define ROTD_PRESC_WIDTH 15
`define ROTD_SEC_PER_MIN 6'h3B
`define ROTD_RATE_1HZ 2'h0
`define ROTD_RATE_4K 2'h1
`define ROTD_RATE_8K 2'h2
`define ROTD_RATE_32K 2'h3
`define ROTD_BIT_1HZ 14
`define ROTD_BIT_4K 2
`define ROTD_BIT_8K 1
`define ROTD_BIT_64HZ 8
`endif

// >>> rotd_tick_sync.v
// two-flop synchroniser with rising-edge pulse for the timebase pin
`timescale 1ns/10ps
`default_nettype none
module rotd_tick_sync (
   input wire clk_sys, // system clock
   input wire sys_rst, // synchronous reset, active high
   input wire pin_in, // asynchronous pin
   output reg level_out, // synchronised level
   output reg rise_pulse // one-cycle pulse on rising edge
);
   reg meta;
   reg prev;

   always @(posedge clk_sys) begin
      if (sys_rst) begin
         meta <= 1'b0;
         level_out <= 1'b0;
         prev <= 1'b0;
         rise_pulse <= 1'b0;
      end else begin
         meta <= pin_in;
         level_out <= meta;
         prev <= level_out;
         rise_pulse <= level_out & ~prev;
      end
   end
endmodule // rotd_tick_sync
`default_nettype wire

// >>> rotd_trim.v
// oscillator digital trim: register, trimmed prescaler, square-wave output
`timescale 1ns/10ps
`default_nettype none
`include "rotd_consts.vh"
module rotd_trim (
   input wire clk_sys, // system clock, 100 MHz
   input wire sys_rst, // synchronous reset, active high
   input wire timebase_in, // 32.768 kHz timebase pin
   input wire [7:0] reg_addr, // register address
   input wire [7:0] reg_wdata, // register write data
   input wire reg_wr, // register write strobe
   output reg [7:0] reg_rdata, // register read data, one cycle after address
   input wire oscillator_run, // crystal oscillator started
   input wire external_clock_select, // external timebase selected
   input wire coarse_trim_enable, // coarse trim mode
   input wire square_wave_enable, // square wave output enable
   input wire [1:0] square_wave_rate_select, // square wave rate
   input wire on_backup, // running from the backup supply
   output reg seconds_tick, // one-cycle pulse per trimmed second
   output reg multi_function_output, // square wave output level
   output reg [7:0] oscillator_trim // trim register contents
);
   // ----------------------------------------------------------------
   // timebase synchroniser
   // ----------------------------------------------------------------
   wire tb_level;
   wire tb_rise;

   rotd_tick_sync u_sync (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .pin_in(timebase_in),
      .level_out(tb_level),
      .rise_pulse(tb_rise)
   );

   wire clock_on = oscillator_run | external_clock_select;
   wire tick = tb_rise & clock_on;

   // ----------------------------------------------------------------
   // register port
   // ----------------------------------------------------------------
   // only one register lives here; other addresses read as zero
   // and ignore writes
   wire trim_selected = (reg_addr == `ROTD_TRIM_ADDR);
   wire trim_write = reg_wr & trim_selected;
   reg [7:0] next_rdata;

   always @* begin
      next_rdata = 8'h00;
      if (trim_selected)
         next_rdata = oscillator_trim;
   end

   always @(posedge clk_sys) begin
      if (sys_rst) begin
         oscillator_trim <= `ROTD_TRIM_RESET;
      end else begin
         if (trim_write)
            oscillator_trim <= reg_wdata;
      end
   end

   always @(posedge clk_sys) begin
      if (sys_rst)
         reg_rdata <= 8'h00;
      else
         reg_rdata <= next_rdata;
   end

   wire [6:0] trim_magnitude = oscillator_trim[`ROTD_MAG_MSB:0];
   wire trim_add = oscillator_trim[`ROTD_DIR_BIT];

   // ----------------------------------------------------------------
   // trim schedule
   // ----------------------------------------------------------------
   reg [7:0] coarse_cnt;
   reg [5:0] sec_cnt;
   reg [14:0] presc;
   reg [7:0] pending;
   reg pend_add;

   // ----------------------------------------------------------------
   // per-tick trim action
   // ----------------------------------------------------------------
   // an add step advances the prescaler by two, a subtract step
   // freezes it for that tick; the seconds tick only ever moves
   wire pend_busy = (pending != 8'h00);
   wire trim_add_now = pend_busy & pend_add;
   wire trim_hold_now = pend_busy & ~pend_add;
   wire [15:0] presc_step = trim_add_now ? 16'h0002 : 16'h0001;
   wire [15:0] next_presc_sum = {1'b0, presc} + presc_step;
   wire sec_wrap = tick & ~trim_hold_now & next_presc_sum[15];
   // coarse application every 256 timebase cycles
   wire coarse_event = tick & (coarse_cnt == 8'hFF) & coarse_trim_enable;
   wire minute_event = sec_wrap & (sec_cnt == `ROTD_SEC_PER_MIN) & ~coarse_trim_enable;
   // repeats with no host action; no supply gating
   wire trim_event = coarse_event | minute_event;

   // coarse counter runs on raw ticks: 128 applications per nominal second
   always @(posedge clk_sys) begin
      if (sys_rst)
         coarse_cnt <= 8'h00;
      else if (tick)
         coarse_cnt <= coarse_cnt + 8'h01;
   end

   // seconds counter follows the trimmed prescaler wrap
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         sec_cnt <= 6'h00;
      end else if (sec_wrap) begin
         if (sec_cnt == `ROTD_SEC_PER_MIN)
            sec_cnt <= 6'h00;
         else
            sec_cnt <= sec_cnt + 6'h01;
      end
   end

   // ----------------------------------------------------------------
   // trimmed prescaler
   // ----------------------------------------------------------------
   reg [14:0] next_presc;
   reg [7:0] next_pending;
   reg next_pend_add;

   always @* begin
      next_presc = presc;
      next_pending = pending;
      next_pend_add = pend_add;
      if (trim_event) begin
         // twice the magnitude; zero gives nothing
         next_pending = {trim_magnitude, 1'b0};
         next_pend_add = trim_add;
      end else if (tick && pend_busy) begin
         next_pending = pending - 8'h01;
      end
      // one extra or one skipped count per timebase cycle
      if (tick && !trim_hold_now)
         next_presc = next_presc_sum[14:0];
   end

   always @(posedge clk_sys) begin
      if (sys_rst) begin
         presc <= 15'h0000;
         pending <= 8'h00;
         pend_add <= 1'b0;
         seconds_tick <= 1'b0;
      end else begin
         presc <= next_presc;
         pending <= next_pending;
         pend_add <= next_pend_add;
         seconds_tick <= sec_wrap;
      end
   end

   // ----------------------------------------------------------------
   // square wave output
   // ----------------------------------------------------------------
   reg next_wave;

   always @* begin
      next_wave = 1'b0;
      if (coarse_trim_enable) begin
         // trimmed 64 Hz in coarse mode
         next_wave = presc[`ROTD_BIT_64HZ];
      end else begin
         case (square_wave_rate_select)
            `ROTD_RATE_1HZ: next_wave = presc[`ROTD_BIT_1HZ];
            `ROTD_RATE_4K: next_wave = presc[`ROTD_BIT_4K];
            `ROTD_RATE_8K: next_wave = presc[`ROTD_BIT_8K];
            `ROTD_RATE_32K: next_wave = tb_level;
            default: next_wave = 1'b0;
         endcase
      end
   end

   always @(posedge clk_sys) begin
      if (sys_rst)
         multi_function_output <= 1'b0;
      else
         multi_function_output <= next_wave & square_wave_enable & clock_on & ~on_backup;
   end
endmodule // rotd_trim
`default_nettype wire

// >>> rotd_trim_checker.sv
// checker for the oscillator trim block ports
`timescale 1ns/10ps
`default_nettype none
module rotd_trim_checker (
   input wire clk_sys, // clock
   input wire sys_rst, // reset
   input wire [7:0] reg_addr, // address
   input wire [7:0] reg_wdata, // write data
   input wire reg_wr, // write strobe
   input wire [7:0] reg_rdata, // read data
   input wire oscillator_run, // oscillator on
   input wire external_clock_select, // external clock
   input wire coarse_trim_enable, // coarse mode
   input wire square_wave_enable, // output enable
   input wire on_backup, // backup supply
   input wire seconds_tick, // second pulse
   input wire multi_function_output, // output pin
   input wire [7:0] oscillator_trim // trim register
);
   // ----------------------------------------
   // port relations
   // ----------------------------------------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   a_trim_write: assert property (reg_wr && reg_addr == 8'h08 |=>
      oscillator_trim == $past(reg_wdata)) else $error("trim write lost");
   a_other_ignored: assert property (reg_wr && reg_addr != 8'h08 |=>
      $stable(oscillator_trim)) else $error("foreign write changed trim");
   a_rdata_zero: assert property (reg_addr != 8'h08 |=>
      reg_rdata == 8'h00) else $error("unmapped read not zero");
   a_rdata_trim: assert property (reg_addr == 8'h08 && !reg_wr |=>
      reg_rdata == $past(oscillator_trim)) else $error("trim read wrong");
   a_reset_clears: assert property ($fell(sys_rst) |-> oscillator_trim == 8'h00 &&
      !seconds_tick && !multi_function_output) else $error("outputs not cleared");
   a_backup_low: assert property (on_backup [*3] |->
      !multi_function_output) else $error("output on backup");
   a_disabled_low: assert property (!square_wave_enable [*3] |->
      !multi_function_output) else $error("output while disabled");
   a_halt_no_tick: assert property ((!oscillator_run && !external_clock_select) [*6] |->
      !seconds_tick) else $error("tick without timebase");
   c_write: cover property (reg_wr && reg_addr == 8'h08);
   c_coarse_out: cover property (coarse_trim_enable && $rose(multi_function_output));
   c_backup: cover property (on_backup && square_wave_enable);
endmodule // rotd_trim_checker
bind rotd_trim rotd_trim_checker chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
   .oscillator_run(oscillator_run), .external_clock_select(external_clock_select),
   .coarse_trim_enable(coarse_trim_enable), .square_wave_enable(square_wave_enable),
   .on_backup(on_backup), .seconds_tick(seconds_tick),
   .multi_function_output(multi_function_output), .oscillator_trim(oscillator_trim));
`default_nettype wire

// >>> rotd_trim_tb_top.sv
// bench for the oscillator trim block
`timescale 1ns/10ps
`default_nettype none
module rotd_trim_tb_top;
   logic clk_sys, sys_rst, reg_wr, run, ext, crs, sqw, bak, mfo_q;
   logic [7:0] addr, wdat;
   logic [2:0] div;
   wire [7:0] rdat, trim;
   wire tick, mfo;
   integer failures, num_checks, cnt, c0, nsec;
   rotd_trim dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .timebase_in(div[2]),
      .reg_addr(addr), .reg_wdata(wdat), .reg_wr(reg_wr), .reg_rdata(rdat),
      .oscillator_run(run), .external_clock_select(ext), .coarse_trim_enable(crs),
      .square_wave_enable(sqw), .square_wave_rate_select(2'h0), .on_backup(bak),
      .seconds_tick(tick), .multi_function_output(mfo), .oscillator_trim(trim));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // ----------------------------------------
   // timebase of one tick per eight clocks, output toggle count
   // ----------------------------------------
   always @(posedge clk_sys) begin
      div <= sys_rst ? 3'h0 : div + 3'h1;
      mfo_q <= mfo;
      cnt <= sys_rst ? 0 : (mfo !== mfo_q) ? cnt + 1 : cnt;
      nsec <= sys_rst ? 0 : nsec + tick;
   end
   task check(input string what, input logic [7:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task wr(input logic [7:0] a, d);
      @(posedge clk_sys); addr <= a; wdat <= d; reg_wr <= 1'b1;
      @(posedge clk_sys); reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, exp);
      @(posedge clk_sys); addr <= a;
      repeat (2) @(posedge clk_sys);
      #1 check("rdata", rdat, exp);
   endtask
   // nominal 8 toggles of the 64 Hz tap over 2048 ticks
   task measure(input logic [7:0] tv, input integer lo, hi);
      wr(8'h08, tv);
      repeat (2048) @(posedge clk_sys);
      c0 = cnt;
      repeat (16384) @(posedge clk_sys);
      check("toggles", {7'h00, cnt - c0 >= lo && cnt - c0 <= hi}, 8'h01);
   endtask
   task tally_and_finish;
      if (failures == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (80000) @(posedge clk_sys);
      failures++;
      tally_and_finish;
   end
   initial begin
      failures = 0; num_checks = 0; sys_rst = 1'b1; reg_wr = 1'b0;
      addr = 8'h00; wdat = 8'h00; run = 1'b1; ext = 1'b0; crs = 1'b0; sqw = 1'b0;
      bak = 1'b0;
      repeat (16) @(posedge clk_sys);
      sys_rst <= 1'b0;
      rd(8'h08, 8'h00);
      wr(8'h08, 8'h85); wr(8'h09, 8'h3C);
      rd(8'h08, 8'h85);
      rd(8'h07, 8'h00);
      wr(8'h08, 8'h00);
      @(posedge clk_sys); crs <= 1'b1; sqw <= 1'b1;
      measure(8'h80, 7, 9);
      measure(8'h40, 3, 5);
      measure(8'hC0, 11, 13);
      wr(8'h08, 8'h00);
      @(posedge clk_sys); bak <= 1'b1; run <= 1'b0; ext <= 1'b1;
      repeat (8) @(posedge clk_sys);
      c0 = cnt;
      repeat (4096) @(posedge clk_sys);
      check("backup", cnt - c0, 8'h00);
      check("seconds", nsec[7:0], 8'h00);
      tally_and_finish;
   end
endmodule // rotd_trim_tb_top
`default_nettype wire
